// ===== rtl/vcr_pkg.sv
// Package of the virtualization capability block: register indexes,
// field positions, masks, reset values and shared types.
// Assumes the core presents register indexes as 32-bit values.
package vcr_pkg;
   // ==========================================================
   // Register indexes
   localparam logic [31:0] IDX_ENTRY_CTL = 32'h0000_0484;
   localparam logic [31:0] IDX_MISC = 32'h0000_0485;
   localparam logic [31:0] IDX_S0_FIX0 = 32'h0000_0486;
   localparam logic [31:0] IDX_S0_FIX1 = 32'h0000_0487;
   localparam logic [31:0] IDX_S4_FIX0 = 32'h0000_0488;
   localparam logic [31:0] IDX_S4_FIX1 = 32'h0000_0489;
   localparam logic [31:0] IDX_FIELD_ENUM = 32'h0000_048a;
   localparam logic [31:0] IDX_EXACT_ENTRY = 32'h0000_0490;
   localparam logic [31:0] IDX_SMBASE = 32'h0000_009e;
   localparam logic [31:0] IDX_TRACE_CTL = 32'h0000_0600;
   localparam logic [31:0] IDX_MON_CTL = 32'h0000_0601;
   // ==========================================================
   // Miscellaneous register field positions
   localparam int MISC_TMR_LSB = 0;
   localparam int MISC_LMA_BIT = 5;
   localparam int MISC_ACT_LSB = 6;
   localparam int MISC_TRACE_BIT = 14;
   localparam int MISC_SMBASE_BIT = 15;
   localparam int MISC_PRT_LSB = 16;
   localparam int MISC_PRT_BIG_BIT = 24;
   localparam int MISC_LIST_LSB = 25;
   localparam int MISC_MON_BIT = 28;
   localparam int MISC_WRANY_BIT = 29;
   localparam int MISC_ZLEN_BIT = 30;
   localparam int MISC_REV_LSB = 32;
   // ==========================================================
   // Control bits and masks
   localparam logic [31:0] DEFAULT_ONE_MASK = 32'h0000_11ff;
   localparam int ENTRY_GUEST64_BIT = 9;
   localparam int TRACE_EN_BIT = 0;
   localparam int MON_BLOCK_BIT = 2;
   // ==========================================================
   // Control structure field encoding
   localparam int ENC_INDEX_LSB = 1;
   localparam int ENC_TYPE_LSB = 10;
   localparam int ENC_RSVD12_BIT = 12;
   localparam int ENC_WIDTH_LSB = 13;
   localparam int ENC_RSVD_HI_LSB = 15;
   localparam logic [1:0] ENC_TYPE_EXIT_INFO = 2'h1;
   // ==========================================================
   // Injection types that carry an instruction length
   localparam logic [2:0] INJ_SW_INT = 3'h4;
   localparam logic [2:0] INJ_PRIV_SW_EXC = 3'h5;
   localparam logic [2:0] INJ_SW_EXC = 3'h6;
   // ==========================================================
   // Reset values
   localparam logic [31:0] TIMER_RST = 32'h0000_0000;
   localparam logic TRACE_EN_RST = 1'b0;
   localparam logic MON_BLOCK_RST = 1'b0;
   // ==========================================================
   // Guest activity states
   typedef enum logic [1:0] {
      ACT_ACTIVE, ACT_HALT, ACT_SHUTDOWN, ACT_WAIT_STARTUP
   } vcr_act_t;
endpackage

// ===== rtl/vcr_entry_if.sv
// Interface between the capability bank and its entry checker.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
interface vcr_entry_if;
   logic [63:0] cap_entry;
   logic [63:0] cap_exact;
   logic [63:0] cap_misc;
   logic [63:0] cap_s0f0, cap_s0f1, cap_s4f0, cap_s4f1;
   logic exact_mode;
   logic [31:0] ctls;
   logic [1:0] activity;
   logic inj_valid;
   logic [2:0] inj_type;
   logic [3:0] inj_len;
   logic [63:0] s0_value;
   logic [63:0] s4_value;
   logic fail;
   modport bank (output cap_entry, cap_exact, cap_misc, cap_s0f0,
      cap_s0f1, cap_s4f0, cap_s4f1, exact_mode, ctls, activity,
      inj_valid, inj_type, inj_len, s0_value, s4_value, input fail);
   modport chk (input cap_entry, cap_exact, cap_misc, cap_s0f0,
      cap_s0f1, cap_s4f0, cap_s4f1, exact_mode, ctls, activity,
      inj_valid, inj_type, inj_len, s0_value, s4_value, output fail);
endinterface

// ===== rtl/vcr_entry_check.sv
// Combinational entry consistency check against the capability words.
// Assumes the bank registers the verdict.
`timescale 1ns/1ps
module vcr_entry_check (
   vcr_entry_if.chk ei
);
   import vcr_pkg::*;

   function automatic logic fixed_bad(input logic [63:0] v,
      input logic [63:0] f0, input logic [63:0] f1);
      fixed_bad = ((v | f0) != v) || ((v & ~f1) != 64'h0);
   endfunction

   logic [31:0] allow0;
   logic [31:0] allow1;
   logic act_bad;
   logic inj_bad;

   always_comb begin
      allow0 = ei.exact_mode ? ei.cap_exact[31:0] : ei.cap_entry[31:0];
      allow1 = ei.exact_mode ? ei.cap_exact[63:32] : ei.cap_entry[63:32];
   end

   always_comb begin
      unique case (vcr_act_t'(ei.activity)) // [R8]
         ACT_ACTIVE: act_bad = 1'b0; // [R9]
         ACT_HALT: act_bad = !ei.cap_misc[MISC_ACT_LSB];
         ACT_SHUTDOWN: act_bad = !ei.cap_misc[MISC_ACT_LSB + 1];
         ACT_WAIT_STARTUP: act_bad = !ei.cap_misc[MISC_ACT_LSB + 2];
      endcase
   end

   always_comb begin
      inj_bad = ei.inj_valid && (ei.inj_len == 4'h0) &&
         !ei.cap_misc[MISC_ZLEN_BIT] && // [R16]
         ((ei.inj_type == INJ_SW_INT) || (ei.inj_type == INJ_SW_EXC) ||
         (ei.inj_type == INJ_PRIV_SW_EXC));
   end

   always_comb begin
      ei.fail = ((allow0 & ~ei.ctls) != 32'h0) || // [R1] [R5]
         (!ei.exact_mode &&
         ((ei.ctls & DEFAULT_ONE_MASK) != DEFAULT_ONE_MASK)) || // [R3]
         ((ei.ctls & ~allow1) != 32'h0) || // [R4]
         act_bad || inj_bad ||
         fixed_bad(ei.s0_value, ei.cap_s0f0, ei.cap_s0f1) || // [R18]
         fixed_bad(ei.s4_value, ei.cap_s4f0, ei.cap_s4f1); // [R19]
   end
endmodule // vcr_entry_check

// ===== rtl/vcr_capability_regs.sv
// Virtualization capability register bank with the logic it steers.
// Assumes index-addressed reads and writes from the core, one per cycle.
//
// Functional notes
// R1: Entry capability low-half one means that entry control must be one.
// R2: Entry controls 0-8 and 12 always read one in the low half.
// R3: Without exact register, cleared default-one entry control fails entry.
// R4: Entry control set while its allowed-one bit is clear fails entry.
// R5: Exact entry register exists only when basic bit 55 is one.
// R6: Preemption timer decrements when counter bit X toggles on increment.
// R7: With misc bit 5, each exit copies long mode into guest64 control.
// R8: Misc bits 8:6 list halt, shutdown and startup-wait support.
// R9: Unsupported activity state fails entry; active state always allowed.
// R10: Without misc bit 14, enter clears trace enable; writes then fault.
// R11: With misc bit 15, management base readable in management mode.
// R12: Misc bits 24:16 count page roots; bit 24 set iff 23:16 clear.
// R13: Software keeps transfer lists at most 512 times N plus one.
// R14: Misc bit 28 makes monitor bit 2 settable; leave unblocks otherwise.
// R15: Without misc bit 29, structure writes to exit info are refused.
// R16: Misc bit 30 allows zero-length software injection.
// R17: Misc 63:32 holds segment revision; bits 13:9 and 31 read zero.
// R18: First control register forced by its fixed-zero and fixed-one pair.
// R19: Fourth control register uses the same scheme with its own pair.
// R20: Field encoding: width 14:13, type 11:10, index 9:1, reserved zero.
// R21: Enumeration bits 9:1 give highest index; other bits read zero.
// R22: Capability registers are constants; writes never change them.
`timescale 1ns/1ps
module vcr_capability_regs #(
   parameter logic BASIC_EXACT = 1'b1,
   parameter logic [31:0] ENTRY_ALLOW0 = 32'h0000_0000,
   parameter logic [31:0] ENTRY_ALLOW1 = 32'h0000_ffff,
   parameter logic [31:0] EXACT_ALLOW0 = 32'h0000_0004,
   parameter logic [31:0] EXACT_ALLOW1 = 32'h0000_ffff,
   parameter logic [4:0] TMR_RATE = 5'h05,
   parameter logic LMA_STORE = 1'b1,
   parameter logic UNRESTRICTED = 1'b1,
   parameter logic [2:0] ACT_MAP = 3'h7,
   parameter logic TRACE_PRESENT = 1'b1,
   parameter logic TRACE_OK = 1'b0,
   parameter logic SMBASE_RD = 1'b1,
   parameter logic [7:0] PRT_LOW = 8'h04,
   parameter logic [2:0] LIST_N = 3'h0,
   parameter logic MON_OK = 1'b1,
   parameter logic WRITE_ANY = 1'b0,
   parameter logic ZLEN_INJECT = 1'b1,
   parameter logic [31:0] SEG_REV = 32'h0000_0001, // Arbitrary value
   parameter logic [63:0] S0_FIX0 = 64'h0000_0000_8000_0021,
   parameter logic [63:0] S0_FIX1 = 64'h0000_0000_ffff_ffff,
   parameter logic [63:0] S4_FIX0 = 64'h0000_0000_0000_2000,
   parameter logic [63:0] S4_FIX1 = 64'h0000_0000_003f_ffff,
   parameter logic [8:0] ENUM_MAX_IDX = 9'h02e
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic rd_req,
   input wire logic [31:0] rd_index,
   input wire logic smm_active,
   input wire logic [63:0] smbase_value,
   output logic rd_valid_reg,
   output logic [63:0] rd_data_reg,
   output logic rd_fault_reg,
   input wire logic wr_req,
   input wire logic [31:0] wr_index,
   input wire logic [63:0] wr_data,
   output logic wr_done_reg,
   output logic wr_fault_reg,
   input wire logic virt_active,
   input wire logic enter_virt,
   input wire logic leave_virt,
   output logic trace_en_reg,
   output logic mon_block_reg,
   output logic smi_unblock_reg,
   input wire logic [63:0] tsc_value,
   input wire logic tsc_inc,
   input wire logic timer_active,
   input wire logic timer_load,
   input wire logic [31:0] timer_load_value,
   output logic [31:0] timer_value_reg,
   output logic timer_expired_reg,
   input wire logic vm_exit,
   input wire logic long_mode_active,
   output logic guest64_reg,
   input wire logic entry_req,
   input wire logic [31:0] entry_ctls,
   input wire logic [1:0] entry_activity,
   input wire logic inj_valid,
   input wire logic [2:0] inj_type,
   input wire logic [3:0] inj_len,
   input wire logic [63:0] sysctl0_value,
   input wire logic [63:0] sysctl4_value,
   output logic entry_done_reg,
   output logic entry_fail_reg,
   input wire logic sw_req,
   input wire logic [31:0] sw_encoding,
   output logic sw_done_reg,
   output logic sw_refused_reg
);
   import vcr_pkg::*;

   // ==========================================================
   // Capability words
   localparam logic [63:0] CAP_ENTRY =
      {ENTRY_ALLOW1, ENTRY_ALLOW0 | DEFAULT_ONE_MASK}; // [R2]
   localparam logic [63:0] CAP_EXACT = {EXACT_ALLOW1, EXACT_ALLOW0};
   localparam logic [63:0] CAP_MISC = {SEG_REV, 1'b0, ZLEN_INJECT,
      WRITE_ANY, MON_OK, LIST_N, PRT_LOW == 8'h00, PRT_LOW, // [R12]
      SMBASE_RD, TRACE_OK, 5'h00, ACT_MAP, // [R17]
      LMA_STORE | UNRESTRICTED, TMR_RATE}; // [R7]
   localparam logic [63:0] CAP_S0F1 = S0_FIX1 | S0_FIX0; // [R18]
   localparam logic [63:0] CAP_S4F1 = S4_FIX1 | S4_FIX0; // [R19]
   localparam logic [63:0] CAP_ENUM =
      {54'h0, ENUM_MAX_IDX, 1'b0}; // [R21]

   // Returns {hit, word} for a capability index
   function automatic logic [64:0] cap_lookup(input logic [31:0] idx);
      unique case (idx)
         IDX_ENTRY_CTL: cap_lookup = {1'b1, CAP_ENTRY};
         IDX_MISC: cap_lookup = {1'b1, CAP_MISC};
         IDX_S0_FIX0: cap_lookup = {1'b1, S0_FIX0};
         IDX_S0_FIX1: cap_lookup = {1'b1, CAP_S0F1};
         IDX_S4_FIX0: cap_lookup = {1'b1, S4_FIX0};
         IDX_S4_FIX1: cap_lookup = {1'b1, CAP_S4F1};
         IDX_FIELD_ENUM: cap_lookup = {1'b1, CAP_ENUM};
         IDX_EXACT_ENTRY: cap_lookup = {BASIC_EXACT, CAP_EXACT}; // [R5]
         default: cap_lookup = {1'b0, 64'h0};
      endcase
   endfunction

   // ==========================================================
   // Register reads
   logic [64:0] rd_cap;
   logic [64:0] wr_cap;
   logic trace_locked;

   always_comb begin
      rd_cap = cap_lookup(rd_index);
      wr_cap = cap_lookup(wr_index);
      trace_locked = virt_active && !CAP_MISC[MISC_TRACE_BIT];
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_valid_reg <= 1'b0;
         rd_data_reg <= 64'h0;
         rd_fault_reg <= 1'b0;
      end else begin
         rd_valid_reg <= rd_req;
         if (rd_req) begin
            rd_fault_reg <= 1'b0;
            if (rd_cap[64]) begin
               rd_data_reg <= rd_cap[63:0];
            end else if (rd_index == IDX_SMBASE && smm_active &&
                  CAP_MISC[MISC_SMBASE_BIT]) begin
               rd_data_reg <= smbase_value; // [R11]
            end else if (rd_index == IDX_TRACE_CTL && TRACE_PRESENT) begin
               rd_data_reg <= {63'h0, trace_en_reg};
            end else if (rd_index == IDX_MON_CTL) begin
               rd_data_reg <= {61'h0, mon_block_reg, 2'h0};
            end else begin
               rd_data_reg <= 64'h0;
               rd_fault_reg <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Register writes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_done_reg <= 1'b0;
         wr_fault_reg <= 1'b0;
      end else begin
         wr_done_reg <= wr_req;
         if (wr_req) begin
            if (wr_cap[64]) begin
               wr_fault_reg <= 1'b1; // [R22]
            end else if (wr_index == IDX_TRACE_CTL) begin
               wr_fault_reg <= !TRACE_PRESENT || trace_locked; // [R10]
            end else if (wr_index == IDX_MON_CTL) begin
               wr_fault_reg <= wr_data[MON_BLOCK_BIT] &&
                  !CAP_MISC[MISC_MON_BIT]; // [R14]
            end else begin
               wr_fault_reg <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Trace enable
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         trace_en_reg <= TRACE_EN_RST;
      end else if (enter_virt && TRACE_PRESENT &&
            !CAP_MISC[MISC_TRACE_BIT]) begin
         trace_en_reg <= 1'b0; // [R10]
      end else if (wr_req && wr_index == IDX_TRACE_CTL && TRACE_PRESENT &&
            !trace_locked) begin
         trace_en_reg <= wr_data[TRACE_EN_BIT];
      end
   end

   // ==========================================================
   // Management monitor control and interrupt unblock
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mon_block_reg <= MON_BLOCK_RST;
      end else if (wr_req && wr_index == IDX_MON_CTL) begin
         mon_block_reg <= wr_data[MON_BLOCK_BIT] &&
            CAP_MISC[MISC_MON_BIT]; // [R14]
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         smi_unblock_reg <= 1'b0;
      end else begin
         smi_unblock_reg <= leave_virt && !mon_block_reg; // [R14]
      end
   end

   // ==========================================================
   // Preemption timer
   logic [63:0] tsc_low_mask;
   logic tsc_bit_toggles;

   always_comb begin
      tsc_low_mask = (64'h1 << CAP_MISC[MISC_TMR_LSB +: 5]) - 64'h1;
      tsc_bit_toggles = tsc_inc &&
         ((tsc_value & tsc_low_mask) == tsc_low_mask); // [R6]
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         timer_value_reg <= TIMER_RST;
      end else if (timer_load) begin
         timer_value_reg <= timer_load_value;
      end else if (timer_active && tsc_bit_toggles &&
            timer_value_reg != 32'h0) begin
         timer_value_reg <= timer_value_reg - 32'h1; // [R6]
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         timer_expired_reg <= 1'b0;
      end else begin
         timer_expired_reg <= timer_active && !timer_load &&
            timer_value_reg == 32'h0;
      end
   end

   // ==========================================================
   // Guest 64-bit entry control
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         guest64_reg <= 1'b0;
      end else if (vm_exit && CAP_MISC[MISC_LMA_BIT]) begin
         guest64_reg <= long_mode_active; // [R7]
      end else if (entry_req) begin
         guest64_reg <= entry_ctls[ENTRY_GUEST64_BIT];
      end
   end

   // ==========================================================
   // Entry consistency check
   vcr_entry_if ei ();

   assign ei.cap_entry = CAP_ENTRY;
   assign ei.cap_exact = CAP_EXACT;
   assign ei.cap_misc = CAP_MISC;
   assign ei.cap_s0f0 = S0_FIX0;
   assign ei.cap_s0f1 = CAP_S0F1;
   assign ei.cap_s4f0 = S4_FIX0;
   assign ei.cap_s4f1 = CAP_S4F1;
   assign ei.exact_mode = BASIC_EXACT;
   assign ei.ctls = entry_ctls;
   assign ei.activity = entry_activity;
   assign ei.inj_valid = inj_valid;
   assign ei.inj_type = inj_type;
   assign ei.inj_len = inj_len;
   assign ei.s0_value = sysctl0_value;
   assign ei.s4_value = sysctl4_value;

   vcr_entry_check u_check (
      .ei(ei.chk)
   );

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         entry_done_reg <= 1'b0;
         entry_fail_reg <= 1'b0;
      end else begin
         entry_done_reg <= entry_req;
         if (entry_req) begin
            entry_fail_reg <= ei.fail; // [R1] [R4] [R9]
         end
      end
   end

   // ==========================================================
   // Structure write check
   logic sw_bad;

   always_comb begin
      sw_bad = (sw_encoding[31:ENC_RSVD_HI_LSB] != 17'h0) ||
         sw_encoding[ENC_RSVD12_BIT] || // [R20]
         (sw_encoding[ENC_INDEX_LSB +: 9] > ENUM_MAX_IDX) ||
         (!CAP_MISC[MISC_WRANY_BIT] &&
         sw_encoding[ENC_TYPE_LSB +: 2] == ENC_TYPE_EXIT_INFO); // [R15]
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sw_done_reg <= 1'b0;
         sw_refused_reg <= 1'b0;
      end else begin
         sw_done_reg <= sw_req;
         if (sw_req) begin
            sw_refused_reg <= sw_bad;
         end
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   chk_exact_absent: assert property ( // [R5]
      rd_req && rd_index == IDX_EXACT_ENTRY && !BASIC_EXACT
      |=> rd_valid_reg && rd_fault_reg)
      else $error("exact entry register readable while absent");
   chk_default_ones: assert property ( // [R2]
      rd_req && rd_index == IDX_ENTRY_CTL
      |=> (rd_data_reg[31:0] & DEFAULT_ONE_MASK) == DEFAULT_ONE_MASK)
      else $error("default-one entry bits read zero");
   chk_prt_count: assert property ( // [R12]
      rd_req && rd_index == IDX_MISC
      |=> rd_data_reg[MISC_PRT_BIG_BIT] == (rd_data_reg[23:16] == 8'h0))
      else $error("page root count encoding broken");
   chk_misc_reserved: assert property ( // [R17]
      rd_req && rd_index == IDX_MISC
      |=> rd_data_reg[13:9] == 5'h0 && !rd_data_reg[31] &&
      rd_data_reg[63:MISC_REV_LSB] == SEG_REV)
      else $error("misc reserved bits or revision wrong");
   chk_enum_reserved: assert property ( // [R21]
      rd_req && rd_index == IDX_FIELD_ENUM
      |=> rd_data_reg[63:10] == 54'h0 && !rd_data_reg[0] &&
      rd_data_reg[9:1] == ENUM_MAX_IDX)
      else $error("enumeration register wrong");
   chk_fixed_pair: assert property ( // [R18]
      rd_req && rd_index == IDX_S0_FIX1 |=> (S0_FIX0 & ~rd_data_reg) == 0)
      else $error("forced-one bit missing from fixed-one report");
   chk_cap_write: assert property ( // [R22]
      wr_req && wr_cap[64] |=> wr_done_reg && wr_fault_reg)
      else $error("capability write accepted");
   chk_trace_clear: assert property ( // [R10]
      enter_virt && TRACE_PRESENT && !TRACE_OK |=> !trace_en_reg)
      else $error("trace enable kept across enter");
   chk_smi_unblock: assert property ( // [R14]
      leave_virt && !mon_block_reg |=> smi_unblock_reg)
      else $error("leave did not unblock interrupts");
   chk_timer_step: assert property ( // [R6]
      timer_active && !timer_load && tsc_bit_toggles &&
      timer_value_reg != 32'h0
      |=> timer_value_reg == $past(timer_value_reg) - 32'h1)
      else $error("preemption timer did not step");
   chk_guest64_copy: assert property ( // [R7]
      vm_exit && CAP_MISC[MISC_LMA_BIT]
      |=> guest64_reg == $past(long_mode_active))
      else $error("long mode flag not copied on exit");
   chk_entry_act: assert property ( // [R9]
      entry_req && entry_activity == 2'h0 |-> !u_check.act_bad)
      else $error("active state entry refused");
   chk_sw_refuse: assert property ( // [R15]
      sw_req && !WRITE_ANY && sw_encoding[11:10] == ENC_TYPE_EXIT_INFO
      |=> sw_done_reg && sw_refused_reg)
      else $error("exit info write accepted");
endmodule // vcr_capability_regs

// ===== test/tb.sv
// Testbench of the virtualization capability bank.
// Assumes the bank's default parameters and a 100 MHz clock.
`timescale 1ns/1ps
module tb;
   import vcr_pkg::*;
   logic clk, arst_n, rd_req, system_management_mode, wr_req, virt, enter_virt, leave_virt;
   logic tsc_inc, timer_load, vm_exit, lma, entry_req, inj_v, sw_req, t_act;
   logic rd_v, rd_f, wr_d, wr_f, tr_en, mon_b, smi_u, t_exp, g64;
   logic e_done, e_fail, sw_d, sw_r;
   logic [31:0] rd_index, wr_index, ctls, sw_enc, t_val;
   logic [63:0] wr_data, timestamp_counter, s0, s4, rd_d;
   logic [1:0] act;
   logic [2:0] inj_t;
   int n_fail = 0;
   int n_checks = 0;
   vcr_capability_regs vcr_capability_regs_i (.clk(clk), .arst_n(arst_n),
      .rd_req(rd_req), .rd_index(rd_index), .smm_active(system_management_mode),
      .smbase_value(64'h000a_5000), .rd_valid_reg(rd_v),
      .rd_data_reg(rd_d), .rd_fault_reg(rd_f), .wr_req(wr_req),
      .wr_index(wr_index), .wr_data(wr_data), .wr_done_reg(wr_d),
      .wr_fault_reg(wr_f), .virt_active(virt), .enter_virt(enter_virt),
      .leave_virt(leave_virt), .trace_en_reg(tr_en), .mon_block_reg(mon_b),
      .smi_unblock_reg(smi_u), .tsc_value(timestamp_counter), .tsc_inc(tsc_inc),
      .timer_active(t_act), .timer_load(timer_load),
      .timer_load_value(32'h3), .timer_value_reg(t_val),
      .timer_expired_reg(t_exp), .vm_exit(vm_exit), .long_mode_active(lma),
      .guest64_reg(g64), .entry_req(entry_req), .entry_ctls(ctls),
      .entry_activity(act), .inj_valid(inj_v), .inj_type(inj_t),
      .inj_len(4'h0), .sysctl0_value(s0), .sysctl4_value(s4),
      .entry_done_reg(e_done), .entry_fail_reg(e_fail), .sw_req(sw_req),
      .sw_encoding(sw_enc), .sw_done_reg(sw_d), .sw_refused_reg(sw_r));
   // ==========================================================
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #20000;
      n_fail++;
      wrap_up();
   end
   // ==========================================================
   // Access tasks
   task automatic chk(input string what, input logic [63:0] exp,
      input logic [63:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd(input logic [31:0] i, input logic [63:0] e,
      input logic f);
      @(posedge clk);
      rd_req <= 1'b1;
      rd_index <= i;
      @(posedge clk);
      rd_req <= 1'b0;
      #1;
      chk("read flags", {62'h0, 1'b1, f}, {62'h0, rd_v, rd_f});
      chk("read data", e, rd_d);
   endtask
   task automatic wr(input logic [31:0] i, input logic [63:0] d,
      input logic f);
      @(posedge clk);
      wr_req <= 1'b1;
      wr_index <= i;
      wr_data <= d;
      @(posedge clk);
      wr_req <= 1'b0;
      #1;
      chk("write flags", {62'h0, 1'b1, f}, {62'h0, wr_d, wr_f});
   endtask
   task automatic ent(input logic [31:0] c, input logic [1:0] a,
      input logic [63:0] v0, input logic [63:0] v4, input logic f);
      @(posedge clk);
      entry_req <= 1'b1;
      ctls <= c;
      act <= a;
      s0 <= v0;
      s4 <= v4;
      @(posedge clk);
      entry_req <= 1'b0;
      #1;
      chk("entry", {62'h0, 1'b1, f}, {62'h0, e_done, e_fail});
   endtask
   task automatic sw(input logic [31:0] c, input logic f);
      @(posedge clk);
      sw_req <= 1'b1;
      sw_enc <= c;
      @(posedge clk);
      sw_req <= 1'b0;
      #1;
      chk("struct write", {62'h0, 1'b1, f}, {62'h0, sw_d, sw_r});
   endtask
   task automatic ev(input int k);
      @(posedge clk);
      enter_virt <= (k == 0);
      leave_virt <= (k == 1);
      vm_exit <= (k == 2);
      tsc_inc <= (k == 3);
      timer_load <= (k == 4);
      @(posedge clk);
      {enter_virt, leave_virt, vm_exit, tsc_inc, timer_load} <= 5'h0;
      #1;
   endtask
   task automatic wrap_up;
      $display("Checks %0d errors %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ==========================================================
   // Test sequence
   initial begin
      {arst_n, rd_req, system_management_mode, wr_req, virt, enter_virt, leave_virt} = 7'h0;
      {tsc_inc, timer_load, vm_exit, lma, entry_req, inj_v, sw_req} = 7'h0;
      {rd_index, wr_index, ctls, sw_enc} = 128'h0;
      {wr_data, s0, s4} = 192'h0;
      timestamp_counter = 64'h1f;
      t_act = 1'b1;
      act = 2'h0;
      inj_t = INJ_SW_INT;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      rd(IDX_ENTRY_CTL, 64'h0000_ffff_0000_11ff, 1'b0);
      rd(IDX_EXACT_ENTRY, 64'h0000_ffff_0000_0004, 1'b0);
      rd(IDX_MISC, 64'h1_5004_81e5, 1'b0);
      rd(IDX_S0_FIX0, 64'h8000_0021, 1'b0);
      rd(IDX_S0_FIX1, 64'hffff_ffff, 1'b0);
      rd(IDX_S4_FIX0, 64'h2000, 1'b0);
      rd(IDX_S4_FIX1, 64'h3f_ffff, 1'b0);
      rd(IDX_FIELD_ENUM, 64'h5c, 1'b0);
      rd(32'h491, 64'h0, 1'b1);
      wr(IDX_MISC, 64'h0, 1'b1);
      rd(IDX_MISC, 64'h1_5004_81e5, 1'b0);
      chk("list limit", 64'h200, 64'h200 * (rd_d[27:25] + 64'h1));
      rd(IDX_SMBASE, 64'h0, 1'b1);
      system_management_mode <= 1'b1;
      rd(IDX_SMBASE, 64'h000a_5000, 1'b0);
      ent(32'h4, 2'h0, 64'h8000_0021, 64'h2000, 1'b0);
      ent(32'h0, 2'h0, 64'h8000_0021, 64'h2000, 1'b1);
      ent(32'h1_0004, 2'h0, 64'h8000_0021, 64'h2000, 1'b1);
      for (int a = 1; a < 4; a++) begin
         ent(32'h4, a[1:0], 64'h8000_0021, 64'h2000, 1'b0);
      end
      ent(32'h4, 2'h0, 64'h0, 64'h2000, 1'b1);
      ent(32'h4, 2'h0, 64'h8000_0021, 64'h40_2000, 1'b1);
      inj_v <= 1'b1;
      for (int t = 4; t < 7; t++) begin
         inj_t <= t[2:0];
         ent(32'h4, 2'h0, 64'h8000_0021, 64'h2000, 1'b0);
      end
      lma <= 1'b1;
      ev(2);
      chk("guest64", 64'h1, {63'h0, g64});
      wr(IDX_TRACE_CTL, 64'h1, 1'b0);
      chk("trace enable", 64'h1, {63'h0, tr_en});
      virt <= 1'b1;
      ev(0);
      chk("trace enable", 64'h0, {63'h0, tr_en});
      wr(IDX_TRACE_CTL, 64'h1, 1'b1);
      chk("trace enable", 64'h0, {63'h0, tr_en});
      wr(IDX_MON_CTL, 64'h4, 1'b0);
      rd(IDX_MON_CTL, 64'h4, 1'b0);
      ev(1);
      chk("unblock", 64'h2, {62'h0, mon_b, smi_u});
      wr(IDX_MON_CTL, 64'h0, 1'b0);
      ev(1);
      chk("unblock", 64'h1, {63'h0, smi_u});
      chk("expired", 64'h1, {63'h0, t_exp});
      ev(4);
      ev(3);
      chk("timer", 64'h2, {32'h0, t_val});
      timestamp_counter <= 64'h1e;
      ev(3);
      chk("timer", 64'h2, {32'h0, t_val});
      t_act <= 1'b0;
      timestamp_counter <= 64'h1f;
      ev(3);
      chk("timer", 64'h2, {31'h0, t_exp, t_val});
      sw(32'h5c, 1'b0);
      sw(32'h5e, 1'b1);
      sw(32'h1000, 1'b1);
      sw(32'h8000, 1'b1);
      sw(32'h400, 1'b1);
      wrap_up();
   end
endmodule // tb
